/* core/smc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_monitor
  import smc_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR   = 7'h2a,
  parameter int unsigned DIV_FAST   = OSC_DIV_60,
  parameter int unsigned DIV_SLOW   = OSC_DIV_50,
  parameter int unsigned VOLT_TICKS = VOLT_CONV_TICKS,
  parameter int unsigned TEMP_TICKS = TEMP_CONV_TICKS
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output var  logic                  sda_out,
  output var  logic                  sda_oe_out,
  output var  logic                  alert_n_out,
  output var  logic                  alert_oe_out,
  input  wire logic [NUM_VOLT*8-1:0] meas_volt_in,
  input  wire logic [7:0]            meas_temp_in,
  output var  logic [2:0]            adc_slot_out,
  output var  logic                  adc_sample_out,
  output var  logic                  shutdown_out
);

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;

  smc_sync #(.WIDTH(2)) u_sync (
    .clk_in (ref_clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .d_in   ({scl_in, sda_in}),
    .q_out  ({scl_s, sda_s})
  );

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else if (ce_in) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ****************************************
  // Serial slave, byte level
  // ****************************************
  smc_ser_state_type state_r;
  logic [3:0]        cnt_r;
  logic [7:0]        sh_r;
  logic [7:0]        tx_r;
  logic [7:0]        ptr_r;
  logic              rw_r;
  logic              wr_stb_r;
  logic              rd_stb_r;
  logic              pin_low_r;
  logic [7:0]        rd_data;

  // Runs whatever the run bit says, so shutdown never locks the host out
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r    <= SER_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      ptr_r      <= 8'h00;
      rw_r       <= 1'h0;
      wr_stb_r   <= 1'h0;
      rd_stb_r   <= 1'h0;
      sda_oe_out <= 1'h0;
    end else if (ce_in) begin
      wr_stb_r <= 1'h0;
      rd_stb_r <= 1'h0;
      if (bus_start) begin
        state_r    <= SER_ADDR;
        cnt_r      <= 4'h0;
        sda_oe_out <= 1'h0;
      end else if (bus_stop) begin
        state_r    <= SER_IDLE;
        sda_oe_out <= 1'h0;
      end else if (scl_rise) begin
        case (state_r)
          SER_ADDR, SER_CMD, SER_WDATA: begin
            sh_r  <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
          SER_RACK: begin
            // Host ack asks for the same register again, a nack ends the read
            state_r <= sda_s ? SER_IDLE : SER_ACK_ADDR;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          SER_ADDR: begin
            if (cnt_r == SER_BITS) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                rw_r       <= sh_r[0];
                sda_oe_out <= 1'h1;
                state_r    <= SER_ACK_ADDR;
              end else begin
                state_r <= SER_IDLE;
              end
            end
          end
          SER_CMD: begin
            if (cnt_r == SER_BITS) begin
              ptr_r      <= sh_r;
              sda_oe_out <= 1'h1;
              state_r    <= SER_ACK_WR;
            end
          end
          SER_WDATA: begin
            if (cnt_r == SER_BITS) begin
              wr_stb_r   <= 1'h1;
              sda_oe_out <= 1'h1;
              state_r    <= SER_ACK_WR;
            end
          end
          SER_ACK_ADDR: begin
            if (rw_r) begin
              tx_r       <= rd_data;
              sda_oe_out <= ~rd_data[7];
              rd_stb_r   <= (ptr_r == ADDR_STAT);
              cnt_r      <= 4'h1;
              state_r    <= SER_RDATA;
            end else begin
              sda_oe_out <= 1'h0;
              cnt_r      <= 4'h0;
              state_r    <= SER_CMD;
            end
          end
          SER_ACK_WR: begin
            sda_oe_out <= 1'h0;
            cnt_r      <= 4'h0;
            state_r    <= SER_WDATA;
          end
          SER_RDATA: begin
            if (cnt_r == SER_BITS) begin
              sda_oe_out <= 1'h0;
              state_r    <= SER_RACK;
            end else begin
              tx_r       <= {tx_r[6:0], 1'h0};
              sda_oe_out <= ~tx_r[6];
              cnt_r      <= cnt_r + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_low_r <= 1'h0;
    end else if (ce_in) begin
      pin_low_r <= 1'h0;
    end
  end
  assign sda_out     = pin_low_r;
  assign alert_n_out = pin_low_r;

  // ****************************************
  // Register file
  // ****************************************
  logic       soft_rst;
  logic       wr_cfg;
  logic [7:0] cfg_r;
  logic [7:0] mask_r;
  logic [7:0] tcfg_r;
  logic [7:0] hot_r;
  logic [7:0] hyst_r;
  logic [7:0] stat_r;
  logic [7:0] vlim_r [NUM_VLIM];
  logic       vlim_hit;
  logic [2:0] vlim_idx;

  assign wr_cfg   = wr_stb_r && (ptr_r == ADDR_CFG);
  assign soft_rst = wr_cfg && sh_r[CFG_SOFT_RST];
  assign vlim_hit = (ptr_r >= ADDR_VLIM_FIRST) && (ptr_r <= ADDR_VLIM_LAST);
  assign vlim_idx = 3'(ptr_r - ADDR_VLIM_FIRST);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= CFG_RESET;
    end else if (ce_in) begin
      if (soft_rst) begin
        cfg_r <= CFG_RESET;
      end else if (wr_cfg) begin
        cfg_r <= sh_r & CFG_WMASK;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_r <= STAT_RESET;
      tcfg_r <= STAT_RESET;
      hot_r  <= HOT_RESET;
      hyst_r <= HYST_RESET;
    end else if (ce_in) begin
      if (soft_rst) begin
        mask_r <= STAT_RESET;
        tcfg_r <= STAT_RESET;
        hot_r  <= HOT_RESET;
        hyst_r <= HYST_RESET;
      end else if (wr_stb_r) begin
        if (ptr_r == ADDR_MASK) mask_r <= sh_r & MASK_WMASK;
        if (ptr_r == ADDR_TCFG) tcfg_r <= sh_r & TCFG_WMASK;
        if (ptr_r == ADDR_HOT) hot_r <= sh_r;
        if (ptr_r == ADDR_HYST) hyst_r <= sh_r;
      end
    end
  end

  // Even entries hold a channel's upper limit, odd ones its lower limit
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_VLIM; i++) begin
        vlim_r[i] <= (i % 2 == 0) ? VHI_RESET : VLO_RESET;
      end
    end else if (ce_in) begin
      if (soft_rst) begin
        for (int i = 0; i < NUM_VLIM; i++) begin
          vlim_r[i] <= (i % 2 == 0) ? VHI_RESET : VLO_RESET;
        end
      end else if (wr_stb_r && vlim_hit) begin
        vlim_r[vlim_idx] <= sh_r;
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    case (ptr_r)
      ADDR_CFG:  rd_data = cfg_r;
      ADDR_STAT: rd_data = stat_r;
      ADDR_MASK: rd_data = mask_r;
      ADDR_TCFG: rd_data = tcfg_r;
      ADDR_HOT:  rd_data = hot_r;
      ADDR_HYST: rd_data = hyst_r;
      default:   rd_data = vlim_hit ? vlim_r[vlim_idx] : 8'h00;
    endcase
  end

  // ****************************************
  // Conversion loop
  // ****************************************
  logic       run;
  logic [2:0] slot;
  logic       slot_done;

  // Clear bit holds the loop off, so the reset value 08h leaves it stopped
  assign run = cfg_r[CFG_RUN] & ~cfg_r[CFG_CLR];

  smc_conv_seq #(
    .DIV_FAST   (DIV_FAST),
    .DIV_SLOW   (DIV_SLOW),
    .VOLT_TICKS (VOLT_TICKS),
    .TEMP_TICKS (TEMP_TICKS)
  ) u_seq (
    .clk_in   (ref_clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .run_in   (run),
    .slow_in  (cfg_r[CFG_SLOW]),
    .short_in (cfg_r[CFG_SHORT]),
    .slot_out (slot),
    .done_out (slot_done)
  );
  assign adc_slot_out   = slot;
  assign adc_sample_out = slot_done;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shutdown_out <= 1'h1;
    end else if (ce_in) begin
      shutdown_out <= ~run;
    end
  end

  // ****************************************
  // Fault detection
  // ****************************************
  logic [7:0] cur_volt;
  logic       v_oor;
  logic       t_hot;
  logic       t_cold;
  logic       temp_done;
  logic       temp_active_r;
  logic       once_hot_r;
  logic       comp_fault_r;
  logic       temp_set;
  logic [1:0] tmode;
  logic [4:0] set_vec;
  logic [4:0] clr_vec;

  assign cur_volt  = meas_volt_in[slot[1:0]*8 +: 8];
  assign v_oor     = (cur_volt < vlim_r[{slot[1:0], 1'h1}])
                   | (cur_volt > vlim_r[{slot[1:0], 1'h0}]);
  assign t_hot     = $signed(meas_temp_in) > $signed(hot_r);
  assign t_cold    = $signed(meas_temp_in) < $signed(hyst_r);
  assign temp_done = slot_done && (slot == SLOT_TEMP);
  assign tmode     = tcfg_r[1:0];

  always_comb begin
    case (tmode)
      TMODE_ONCE: temp_set = (t_hot & ~once_hot_r) | (once_hot_r & t_cold);
      TMODE_COMP: temp_set = t_hot;
      default:    temp_set = t_hot | (temp_active_r & ~t_cold);
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      temp_active_r <= 1'h0;
      once_hot_r    <= 1'h0;
      comp_fault_r  <= 1'h0;
    end else if (ce_in && temp_done) begin
      temp_active_r <= t_hot | (temp_active_r & ~t_cold);
      once_hot_r    <= once_hot_r ? ~t_cold : t_hot;
      comp_fault_r  <= t_hot;
    end
  end

  for (genvar g = 0; g < NUM_VOLT; g++) begin : g_volt
    assign set_vec[g] = slot_done && (slot == 3'(g)) && v_oor && !mask_r[g];
  end
  assign set_vec[STAT_TEMP] = temp_done && temp_set && !mask_r[STAT_TEMP];

  // Comparator mode keeps the temperature bit while the fault is still seen
  assign clr_vec = !rd_stb_r ? 5'h00 :
                   ((tmode == TMODE_COMP) && comp_fault_r) ? STAT_VOLTS : STAT_ALL;

  // New faults win over a same-cycle read clear; the clear bit never touches it
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_r <= STAT_RESET;
    end else if (ce_in) begin
      if (soft_rst) begin
        stat_r <= STAT_RESET;
      end else begin
        stat_r <= {3'h0, (stat_r[4:0] & ~clr_vec) | set_vec};
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alert_oe_out <= 1'h0;
    end else if (ce_in) begin
      alert_oe_out <= cfg_r[CFG_ALERT_EN] & ~cfg_r[CFG_CLR]
                    & (|(stat_r[4:0] & ~mask_r[4:0]));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_stop_no_conv: assert property (ce_in && !run ##1 ce_in |=> !slot_done)
    else $error("conversion finished while stopped");
  a_alert_enable_gate: assert property (ce_in && !cfg_r[CFG_ALERT_EN] |=> !alert_oe_out)
    else $error("alert driven while disabled");
  a_alert_clear_force: assert property (ce_in && cfg_r[CFG_CLR] |=> !alert_oe_out && shutdown_out)
    else $error("alert or loop active with clear bit set");
  a_clear_keeps_status: assert property (ce_in && cfg_r[CFG_CLR] && !rd_stb_r && !soft_rst && !slot_done
                                         |=> $stable(stat_r))
    else $error("clear bit changed status");
  a_soft_reset_cfg: assert property (ce_in && soft_rst |=> cfg_r == CFG_RESET && stat_r == STAT_RESET)
    else $error("soft reset did not restore defaults");
  a_volt_fault_set: assert property (ce_in && slot_done && slot != SLOT_TEMP && v_oor && !mask_r[slot]
                                     && !soft_rst |=> stat_r[$past(slot)])
    else $error("voltage fault not flagged");
  a_read_clears_stat: assert property (ce_in && rd_stb_r && tmode != TMODE_COMP && !slot_done && !soft_rst
                                       |=> stat_r == STAT_RESET)
    else $error("status read did not clear");
  a_comp_keeps_temp: assert property (ce_in && rd_stb_r && tmode == TMODE_COMP && comp_fault_r
                                      && stat_r[STAT_TEMP] && !soft_rst |=> stat_r[STAT_TEMP])
    else $error("comparator fault bit lost on read");
  a_mask_no_alert: assert property (ce_in && ((stat_r[4:0] & ~mask_r[4:0]) == 5'h00) |=> !alert_oe_out)
    else $error("masked fault drove alert");
  a_reserved_zero: assert property ((cfg_r & ~CFG_WMASK) == 8'h00 && stat_r[7:5] == 3'h0)
    else $error("reserved bit set");

endmodule : smc_monitor
`default_nettype wire

/* inc/smc_pkg.sv */
// Functional notes
// - Run bit cleared halts the monitoring loop and enters shutdown.
// - Serial register access keeps working during shutdown.
// - Run bit set starts the loop; host should program limits first.
// - Alert enable bit gates faults onto the alert output.
// - Alert clear bit forces the alert output deasserted.
// - Alert clear bit leaves the fault status register untouched.
// - Configuration resets to 08h; loop waits until clear bit is zero.
// - Rate bit selects 51.2kHz internal conversion clock, else 61.4kHz.
// - Short-cycle bit cuts every conversion to a quarter of its length.
// - Writing bit 7 returns all registers to defaults; bit 7 self-clears.
// - Status bits 0-3 are mid, low, high rail and supply; bit 4 temperature.
// - A limit crossing sets the matching status bit.
// - Temperature status setting and clearing follow the temperature interrupt mode.
// - Hot limit powers up at 50h, meaning +80 degrees.
// - Hot hysteresis limit powers up at 41h, meaning +65 degrees.
// - Voltage limits live at 2Bh-32h; out-of-window voltage raises a fault.
// - Voltage limits default to 1.1 and 0.9 times the nominal code.
// - In default and one-time modes a status read clears the register.
// - Mode bits: 00 default, 01 one-time, 10 comparator, 11 default.
// - Comparator mode read keeps bit 4 while the fault persists.
// - Mask bits suppress both the status bit and the alert.
// - A persisting fault reasserts the alert after the next conversion; in one-time mode a persisting hot fault does not.
`default_nettype none
package smc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned OSC_60_HZ       = 61_400;
  localparam int unsigned OSC_50_HZ       = 51_200;
  localparam int unsigned OSC_DIV_60      = CLK_HZ / OSC_60_HZ;
  localparam int unsigned OSC_DIV_50      = CLK_HZ / OSC_50_HZ;
  localparam int unsigned TEMP_CONV_MS    = 66;
  localparam int unsigned VOLT_CONV_MS    = 33;
  localparam int unsigned TEMP_CONV_TICKS = TEMP_CONV_MS * OSC_60_HZ / 1000;
  localparam int unsigned VOLT_CONV_TICKS = VOLT_CONV_MS * OSC_60_HZ / 1000;
  localparam int unsigned SHORT_SHIFT     = 2;
  localparam int unsigned CNT_W           = 13;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_VLIM_FIRST = 8'h2b;
  localparam logic [7:0] ADDR_VLIM_LAST  = 8'h32;
  localparam logic [7:0] ADDR_HOT        = 8'h39;
  localparam logic [7:0] ADDR_HYST       = 8'h3a;
  localparam logic [7:0] ADDR_CFG        = 8'h40;
  localparam logic [7:0] ADDR_STAT       = 8'h41;
  localparam logic [7:0] ADDR_MASK       = 8'h43;
  localparam logic [7:0] ADDR_TCFG       = 8'h4b;

  localparam int unsigned CFG_RUN      = 0;
  localparam int unsigned CFG_ALERT_EN = 1;
  localparam int unsigned CFG_CLR      = 3;
  localparam int unsigned CFG_SLOW     = 4;
  localparam int unsigned CFG_SHORT    = 5;
  localparam int unsigned CFG_SOFT_RST = 7;

  localparam logic [7:0] CFG_RESET  = 8'h08;
  localparam logic [7:0] CFG_WMASK  = 8'h3b;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [4:0] STAT_ALL   = 5'h1f;
  localparam logic [4:0] STAT_VOLTS = 5'h0f;
  localparam logic [7:0] MASK_WMASK = 8'h1f;
  localparam logic [7:0] TCFG_WMASK = 8'h03;
  localparam logic [7:0] HOT_RESET  = 8'h50;
  localparam logic [7:0] HYST_RESET = 8'h41;
  localparam int unsigned NOM_CODE  = 192;
  localparam logic [7:0] VHI_RESET  = 8'(NOM_CODE * 11 / 10);
  localparam logic [7:0] VLO_RESET  = 8'(NOM_CODE * 9 / 10);

  localparam int unsigned NUM_VOLT  = 4;
  localparam int unsigned NUM_VLIM  = 8;
  localparam int unsigned STAT_TEMP = 4;
  localparam logic [2:0]  SLOT_TEMP = 3'h4;
  localparam logic [1:0]  TMODE_ONCE = 2'h1;
  localparam logic [1:0]  TMODE_COMP = 2'h2;
  localparam logic [3:0]  SER_BITS   = 4'h8;

  typedef enum logic [2:0] {
    SER_IDLE     = 3'h0,
    SER_ADDR     = 3'h1,
    SER_ACK_ADDR = 3'h3,
    SER_CMD      = 3'h2,
    SER_ACK_WR   = 3'h6,
    SER_WDATA    = 3'h7,
    SER_RDATA    = 3'h5,
    SER_RACK     = 3'h4
  } smc_ser_state_type;

endpackage : smc_pkg
`default_nettype wire

/* core/smc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        meta_r[g] <= 1'h1;
        q_out[g]  <= 1'h1;
      end else if (ce_in) begin
        meta_r[g] <= d_in[g];
        q_out[g]  <= meta_r[g];
      end
    end
  end
endmodule : smc_sync
`default_nettype wire

/* core/smc_conv_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_conv_seq
  import smc_pkg::*;
#(
  parameter int unsigned DIV_FAST   = OSC_DIV_60,
  parameter int unsigned DIV_SLOW   = OSC_DIV_50,
  parameter int unsigned VOLT_TICKS = VOLT_CONV_TICKS,
  parameter int unsigned TEMP_TICKS = TEMP_CONV_TICKS
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic       run_in,
  input  wire logic       slow_in,
  input  wire logic       short_in,
  output var  logic [2:0] slot_out,
  output var  logic       done_out
);
  logic [CNT_W-1:0] div_r;
  logic [CNT_W-1:0] tick_r;
  logic [CNT_W-1:0] div_lim;
  logic [CNT_W-1:0] slot_len;
  logic [CNT_W-1:0] slot_lim;

  // Slower oscillator keeps the same tick count, so integration spans whole mains periods
  assign div_lim  = slow_in ? CNT_W'(DIV_SLOW - 1) : CNT_W'(DIV_FAST - 1);
  assign slot_len = (slot_out == SLOT_TEMP) ? CNT_W'(TEMP_TICKS) : CNT_W'(VOLT_TICKS);
  assign slot_lim = (short_in ? (slot_len >> SHORT_SHIFT) : slot_len) - CNT_W'(1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r    <= '0;
      tick_r   <= '0;
      slot_out <= '0;
      done_out <= 1'h0;
    end else if (ce_in) begin
      done_out <= 1'h0;
      if (!run_in) begin
        div_r    <= '0;
        tick_r   <= '0;
        slot_out <= '0;
      end else if (div_r >= div_lim) begin
        div_r <= '0;
        if (tick_r >= slot_lim) begin
          tick_r   <= '0;
          done_out <= 1'h1;
          slot_out <= (slot_out == SLOT_TEMP) ? 3'h0 : slot_out + 3'h1;
        end else begin
          tick_r <= tick_r + CNT_W'(1);
        end
      end else begin
        div_r <= div_r + CNT_W'(1);
      end
    end
  end
endmodule : smc_conv_seq
`default_nettype wire

/* tb/smc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  output var  logic scl_out,
  output var  logic sda_low_out,
  input  wire logic sda_in
);
  // ****
  // Serial host, 64 ns bit time
  // ****
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    sda_low_out = !b;
    #16 scl_out = 1'b1;
    #16 r = sda_in;
    #16 scl_out = 1'b0;
    #16;
  endtask : bit_x
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(1'b1, k);
  endtask : byte_x
  // Also serves as repeated start: sda released while scl low
  task automatic start_x;
    sda_low_out = 1'b0;
    #16 scl_out = 1'b1;
    #16 sda_low_out = 1'b1;
    #16 scl_out = 1'b0;
    #16;
  endtask : start_x
  task automatic stop_x;
    sda_low_out = 1'b1;
    #16 scl_out = 1'b1;
    #16 sda_low_out = 1'b0;
    #16;
  endtask : stop_x
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic [2:0] k;
    start_x();
    byte_x({ADDR, 1'b0}, r, k[0]);
    byte_x(a, r, k[1]);
    byte_x(d, r, k[2]);
    stop_x();
    ok = (k === 3'h0);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic [3:0] k;
    start_x();
    byte_x({ADDR, 1'b0}, r, k[0]);
    byte_x(a, r, k[1]);
    start_x();
    byte_x({ADDR, 1'b1}, r, k[2]);
    byte_x(8'hff, d, k[3]);
    stop_x();
    ok = (k[2:0] === 3'h0);
  endtask : read_reg
endmodule : smc_host_model
`default_nettype wire

/* tb/smc_monitor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_monitor_tb_top;
  import smc_pkg::*;
  logic        ref_clk_in, rst_in, scl, host_low, dut_oe, alert_oe, shut, ok;
  logic [31:0] volt;
  logic [7:0]  temp, rd, ex;
  wire logic   sda = !(host_low | dut_oe);
  int          mismatches, checks_done, cycles, seed;
  smc_host_model host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));
  smc_monitor #(.DIV_FAST(2), .DIV_SLOW(3), .VOLT_TICKS(8), .TEMP_TICKS(16)) DUT (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(dut_oe), .alert_n_out(), .alert_oe_out(alert_oe),
    .meas_volt_in(volt), .meas_temp_in(temp), .adc_slot_out(), .adc_sample_out(),
    .shutdown_out(shut));
  // ****
  // Checking
  // ****
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : check
  // Window limits are the power-up defaults
  function automatic logic [7:0] model(input logic [31:0] v, input logic [7:0] t, input logic [7:0] m);
    int r;
    r = 0;
    for (int c = 0; c < 4; c++) if (v[c*8+:8] > 192*11/10 || v[c*8+:8] < 192*9/10) r |= 1 << c;
    if ($signed(t) > 80) r |= 16;
    return 8'(r) & ~m;
  endfunction : model
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
    host.read_reg(a, rd, ok);
    check(w, rd, e);
    check("rack", {7'h0, ok}, 8'h01);
  endtask : rc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    check("wack", {7'h0, ok}, 8'h01);
  endtask : wr
  task automatic bit_chk(input string w, input logic s, input logic e);
    @(negedge ref_clk_in);
    check(w, {7'h0, s}, {7'h0, e});
  endtask : bit_chk
  task automatic wait_alert;
    for (int i = 0; i < 400 && alert_oe !== 1'b1; i++) @(negedge ref_clk_in);
    bit_chk("alert", alert_oe, 1'b1);
  endtask : wait_alert
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    cycles = 0;
    forever @(posedge ref_clk_in) if (++cycles > 60000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    seed = 32'h78ab;
    rst_in = 1'b1;
    volt = {4{8'd192}};
    temp = 8'd25;
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in) rst_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    bit_chk("shut", shut, 1'b1);
    rc(ADDR_CFG, 8'h08, "cfg");
    rc(ADDR_HOT, 8'h50, "hot");
    rc(ADDR_HYST, 8'h41, "hyst");
    for (int a = 8'h2b; a <= 8'h32; a++) rc(8'(a), a[0] ? 8'(192*11/10) : 8'(192*9/10), "vlim");
    wr(ADDR_CFG, 8'h7f);
    rc(ADDR_CFG, 8'h3b, "rsv");
    bit_chk("shut", shut, 1'b1);
    wr(ADDR_HOT, 8'h60);
    wr(ADDR_CFG, 8'h80);
    rc(ADDR_CFG, 8'h08, "srst");
    rc(ADDR_HOT, 8'h50, "srst");
    wr(ADDR_STAT, 8'hff);
    rc(ADDR_STAT, 8'h00, "stat");
    @(negedge ref_clk_in);
    for (int c = 0; c < 4; c++) volt[c*8+:8] = 8'(150 + {$random(seed)} % 91);
    volt[({$random(seed)} % 4)*8+:8] = 8'hf5;
    ex = model(volt, temp, 8'h00);
    wr(ADDR_CFG, 8'h33);
    bit_chk("shut", shut, 1'b0);
    wait_alert();
    wr(ADDR_CFG, 8'h0b);
    bit_chk("alert", alert_oe, 1'b0);
    bit_chk("shut", shut, 1'b1);
    rc(ADDR_STAT, ex, "stat");
    rc(ADDR_STAT, 8'h00, "stat");
    wr(ADDR_CFG, 8'h01);
    repeat (300) @(negedge ref_clk_in);
    bit_chk("alert", alert_oe, 1'b0);
    rc(ADDR_STAT, ex, "stat");
    wr(ADDR_CFG, 8'h00);
    bit_chk("shut", shut, 1'b1);
    rc(ADDR_CFG, 8'h00, "cfg");
    // Loop ran since the last read, so voltage faults are latched again
    rc(ADDR_STAT, ex, "stat");
    wr(ADDR_TCFG, 8'h02);
    wr(ADDR_MASK, 8'h0f);
    @(negedge ref_clk_in) temp = 8'd90;
    ex = model(volt, temp, 8'h0f);
    wr(ADDR_CFG, 8'h13);
    wait_alert();
    rc(ADDR_STAT, ex, "cmp");
    rc(ADDR_STAT, 8'h10, "cmp");
    @(negedge ref_clk_in) temp = 8'd25;
    repeat (300) @(negedge ref_clk_in);
    rc(ADDR_STAT, 8'h10, "cmp");
    rc(ADDR_STAT, 8'h00, "cmp");
    bit_chk("alert", alert_oe, 1'b0);
    // One-time mode flags the hot crossing once, then the fall below hysteresis
    wr(ADDR_TCFG, 8'h01);
    @(negedge ref_clk_in) temp = 8'h5a;
    repeat (300) @(negedge ref_clk_in);
    rc(ADDR_STAT, 8'h10, "once");
    repeat (300) @(negedge ref_clk_in);
    rc(ADDR_STAT, 8'h00, "once");
    @(negedge ref_clk_in) temp = 8'h19;
    repeat (300) @(negedge ref_clk_in);
    rc(ADDR_STAT, 8'h10, "once");
    // Mode 11 behaves as default: keeps flagging between hysteresis and hot
    wr(ADDR_TCFG, 8'h03);
    @(negedge ref_clk_in) temp = 8'h5a;
    repeat (300) @(negedge ref_clk_in);
    @(negedge ref_clk_in) temp = 8'h46;
    rc(ADDR_STAT, 8'h10, "dflt");
    repeat (300) @(negedge ref_clk_in);
    rc(ADDR_STAT, 8'h10, "dflt");
    close_out();
  end
endmodule : smc_monitor_tb_top
`default_nettype wire
